// [verilog/qrp_pkg.sv]
/*
 * Package of the flash mode and soft reset decoder: opcodes, fields, timing, types.
 * Assumes one core clock of 100 MHz.
 */
package qrp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Opcodes handled by the decoder.
   localparam logic [7:0] OP_SET_READ_PARAM = 8'hC0;
   localparam logic [7:0] OP_WRAP_READ      = 8'h0C;
   localparam logic [7:0] OP_FAST_READ      = 8'h0B;
   localparam logic [7:0] OP_QUAD_IO_READ   = 8'hEB;
   localparam logic [7:0] OP_ENTER_QUAD_CMD = 8'h38;
   localparam logic [7:0] OP_LEAVE_QUAD_CMD = 8'hFF;
   localparam logic [7:0] OP_RESET_ENABLE   = 8'h66;
   localparam logic [7:0] OP_RESET          = 8'h99;
   localparam logic [7:0] OP_SET_BURST_WRAP = 8'h77;

   ////////////////////////////////////////////////////////////////////////////
   // Link phase lengths, counted in serial clock rising edges.
   localparam logic [4:0] SPI_OPCODE_EDGES  = 5'h08;
   localparam logic [4:0] QUAD_OPCODE_EDGES = 5'h02;
   localparam logic [4:0] QUAD_ADDR_EDGES   = 5'h06;
   localparam logic [4:0] PARAM_BYTE_EDGES  = 5'h02;
   localparam logic [4:0] WRAP_CFG_EDGES    = 5'h08;
   localparam logic [4:0] BYTE_EDGES        = 5'h02;

   // Fixed dummy clocks of the single line fast reads.
   localparam logic [3:0] SPI_FAST_READ_DUMMY = 4'h8;
   localparam logic [3:0] SPI_QUAD_IO_DUMMY   = 4'h4;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions in the read parameter byte and the wrap setting byte.
   localparam int DUMMY_FIELD_MSB = 5;
   localparam int DUMMY_FIELD_LSB = 4;
   localparam int WRAP_FIELD_MSB  = 1;
   localparam int WRAP_FIELD_LSB  = 0;
   localparam int SPI_WRAP_LSB    = 4;
   localparam int SPI_LEN_MSB     = 5;
   localparam int SPI_LEN_LSB     = 4;

   // Values after power-up and after a software reset.
   localparam logic [1:0] DUMMY_SEL_RESET    = 2'h0;
   localparam logic [1:0] WRAP_SEL_RESET     = 2'h0;
   localparam logic [2:0] WRAP_SETTING_RESET = 3'h1;

   ////////////////////////////////////////////////////////////////////////////
   // Core clock period and the default reset recovery time.
   localparam int CLK_PERIOD_NS     = 10;
   localparam int RESET_RECOVERY_NS = 30000;

   // Link decoder states.
   typedef enum logic [2:0] {
      QRP_IDLE,
      QRP_OPCODE,
      QRP_PARAM,
      QRP_ADDR,
      QRP_DUMMY,
      QRP_DATA,
      QRP_TAIL
   } qrp_state_type;

   // Read configuration seen by the data path.
   typedef struct packed {
      logic [3:0] dummy_clocks;
      logic [6:0] wrap_bytes;
   } qrp_read_cfg_type;

   // Byte address request towards the memory array.
   typedef struct packed {
      logic        strobe;
      logic        wrapped;
      logic [23:0] addr;
   } qrp_read_req_type;

endpackage : qrp_pkg

// [verilog/qrp_mode_ctrl.sv]
/*
 * Decoder of serial flash mode switching, read parameters,
 * wrapped burst reads and the two step software reset.
 * Assumes link signals come straight from the pins and
 * that the memory array answers each byte address request.
 */
//
// Behaviour
// - Four bit mode C0h sets read dummy clocks and wrap length.
// - C0h is ignored in single line mode.
// - Single line mode fast reads use fixed dummy counts.
// - 77h sets single line wrap length; kept into four bit mode.
// - Reset defaults: wrap 8 bytes, 2 dummy clocks.
// - Dummy field 0 to 3 selects 2, 4, 6, 8 clocks.
// - Wrap field 0 to 3 selects 8, 16, 32, 64 bytes.
// - 0Ch reads like fast read, wrapping in the aligned window.
// - One mode at a time; only 38h enters four bit mode.
// - Power-up starts in single line mode.
// - 38h is ignored while the quad enable bit is 0.
// - Mode changes keep write latch, suspend state and wrap length.
// - FFh returns from four bit to single line mode.
// - Accepted reset aborts work and clears volatile settings.
// - 66h then 99h resets, in either mode.
// - Any other command after 66h cancels the arming.
// - No command is accepted during reset recovery.
module qrp_mode_ctrl #(
   parameter int RESET_RECOVERY_NS = qrp_pkg::RESET_RECOVERY_NS
) (
   input  wire logic                      core_clk,
   input  wire logic                      resetn,
   input  wire logic                      sclk,
   input  wire logic                      cs_n,
   input  wire logic [3:0]                io_in,
   input  wire logic                      quad_enable_bit,
   output logic                           four_bit_command_mode,
   output qrp_pkg::qrp_read_cfg_type      quad_read_cfg,
   output logic [3:0]                     active_dummy_clocks,
   output logic [2:0]                     wrap_setting_bits,
   output qrp_pkg::qrp_read_req_type      read_req,
   output logic                           volatile_clear,
   output logic                           reset_recovering
);

   // Recovery time in core clock cycles, rounded up, at least one.
   localparam int RECOVERY_RAW    = (RESET_RECOVERY_NS + qrp_pkg::CLK_PERIOD_NS - 1)
                                    / qrp_pkg::CLK_PERIOD_NS;
   localparam int RECOVERY_CYCLES = (RECOVERY_RAW < 1) ? 1 : RECOVERY_RAW;
   localparam logic [15:0] RECOVERY_LAST = 16'(RECOVERY_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Shared decoding.

   // Dummy field to clock count: 2, 4, 6 or 8.
   function automatic logic [3:0] dummy_decode(input logic [1:0] sel);
      dummy_decode = {1'b0, sel, 1'b0} + 4'h2;
   endfunction

   // Wrap field to window length in bytes: 8, 16, 32 or 64.
   function automatic logic [6:0] wrap_decode(input logic [1:0] sel);
      wrap_decode = 7'h08 << sel;
   endfunction

   // Next byte address, linear or wrapped in the window.
   function automatic logic [23:0] next_address(input logic [23:0] addr,
                                                input logic        wrap,
                                                input logic [6:0]  len);
      logic [23:0] mask;
      logic [23:0] inc;
      mask = {17'h0, len - 7'h01};
      inc  = addr + 24'h000001;
      next_address = wrap ? ((addr & ~mask) | (inc & mask)) : inc;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the first stage is read only by the second.
   logic [5:0] pin_meta;
   logic [5:0] pin_sync;
   logic       sclk_prev;
   logic       cs_n_prev;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         pin_meta  <= 6'h3F;
         pin_sync  <= 6'h3F;
         sclk_prev <= 1'b1;
         cs_n_prev <= 1'b1;
      end else begin
         pin_meta  <= {sclk, cs_n, io_in};
         pin_sync  <= pin_meta;
         sclk_prev <= pin_sync[5];
         cs_n_prev <= pin_sync[4];
      end
   end

   logic       sclk_rise;
   logic       cs_rise;
   logic       cs_low;
   logic [3:0] io_s;

   // Edge detection on the synchronised link signals.
   assign sclk_rise = pin_sync[5] && !sclk_prev && !pin_sync[4];
   assign cs_rise   = pin_sync[4] && !cs_n_prev;
   assign cs_low    = !pin_sync[4];
   assign io_s      = pin_sync[3:0];

   ////////////////////////////////////////////////////////////////////////////
   // Volatile settings and the reset sequencing state.
   logic        quad_mode;
   logic [1:0]  dummy_sel;
   logic [1:0]  wrap_sel;
   logic        spi_wrap_off;
   logic        reset_armed;
   logic [15:0] recovery_count;

   // Link decoder state.
   qrp_pkg::qrp_state_type state;
   logic [4:0]  edge_count;
   logic [4:0]  phase_edges;
   logic [23:0] shift;
   logic [7:0]  opcode;
   logic        opcode_done;
   logic        param_done;
   logic [23:0] byte_addr;
   logic        wrap_read;

   logic [7:0]  next_shift_byte;
   logic [23:0] next_shift;
   logic        phase_last;
   logic        take_reset;

   // One more bit or nibble, depending on mode and phase.
   always_comb begin
      if (!quad_mode && state == qrp_pkg::QRP_OPCODE) begin
         next_shift = {shift[22:0], io_s[0]};
      end else begin
         next_shift = {shift[19:0], io_s};
      end
      next_shift_byte = next_shift[7:0];
      phase_last      = (edge_count == phase_edges - 5'h01);
   end

   // A complete 99h right after 66h, outside recovery, resets the device.
   assign take_reset = cs_rise && opcode_done && opcode == qrp_pkg::OP_RESET
                       && reset_armed && !reset_recovering;

   ////////////////////////////////////////////////////////////////////////////
   // Reset recovery window; commands are dropped meanwhile.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         reset_recovering <= 1'b0;
         recovery_count   <= 16'h0000;
      end else if (take_reset) begin
         reset_recovering <= 1'b1;
         recovery_count   <= 16'h0000;
      end else if (reset_recovering) begin
         if (recovery_count == RECOVERY_LAST) begin
            reset_recovering <= 1'b0;
         end
         recovery_count <= recovery_count + 16'h0001;
      end
   end

   // Pulse that tells the rest of the device to drop its volatile state.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         volatile_clear <= 1'b0;
      end else begin
         volatile_clear <= take_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset arming: set by 66h, dropped by any other complete command.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         reset_armed <= 1'b0;
      end else if (cs_rise && opcode_done && !reset_recovering) begin
         reset_armed <= (opcode == qrp_pkg::OP_RESET_ENABLE);
      end else if (take_reset) begin
         reset_armed <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Protocol mode; the write latch and suspend state live elsewhere and are
   // not touched here, and the wrap length is shared by both modes.
   always_ff @(posedge core_clk) begin
      if (!resetn || take_reset) begin
         quad_mode <= 1'b0;
      end else if (cs_rise && opcode_done && !reset_recovering) begin
         if (!quad_mode && opcode == qrp_pkg::OP_ENTER_QUAD_CMD && quad_enable_bit) begin
            quad_mode <= 1'b1;
         end else if (quad_mode && opcode == qrp_pkg::OP_LEAVE_QUAD_CMD) begin
            quad_mode <= 1'b0;
         end
      end
   end

   // Read parameters from C0h in four bit mode, wrap setting from 77h otherwise.
   always_ff @(posedge core_clk) begin
      if (!resetn || take_reset) begin
         dummy_sel    <= qrp_pkg::DUMMY_SEL_RESET;
         wrap_sel     <= qrp_pkg::WRAP_SEL_RESET;
         spi_wrap_off <= qrp_pkg::WRAP_SETTING_RESET[0];
      end else if (cs_rise && param_done && !reset_recovering) begin
         if (quad_mode && opcode == qrp_pkg::OP_SET_READ_PARAM) begin
            dummy_sel <= shift[qrp_pkg::DUMMY_FIELD_MSB:qrp_pkg::DUMMY_FIELD_LSB];
            wrap_sel  <= shift[qrp_pkg::WRAP_FIELD_MSB:qrp_pkg::WRAP_FIELD_LSB];
         end else if (!quad_mode && opcode == qrp_pkg::OP_SET_BURST_WRAP) begin
            wrap_sel     <= shift[qrp_pkg::SPI_LEN_MSB:qrp_pkg::SPI_LEN_LSB];
            spi_wrap_off <= shift[qrp_pkg::SPI_WRAP_LSB];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link decoder: opcode, parameter, address, dummy and data phases.
   always_ff @(posedge core_clk) begin
      if (!resetn || take_reset) begin
         state       <= qrp_pkg::QRP_IDLE;
         edge_count  <= 5'h00;
         phase_edges <= qrp_pkg::SPI_OPCODE_EDGES;
         shift       <= 24'h000000;
         opcode      <= 8'h00;
         opcode_done <= 1'b0;
         param_done  <= 1'b0;
         wrap_read   <= 1'b0;
      end else if (!cs_low) begin
         state       <= qrp_pkg::QRP_IDLE;
         edge_count  <= 5'h00;
         phase_edges <= quad_mode ? qrp_pkg::QUAD_OPCODE_EDGES
                                  : qrp_pkg::SPI_OPCODE_EDGES;
         if (cs_rise) begin
            opcode_done <= 1'b0;
            param_done  <= 1'b0;
         end
      end else if (state == qrp_pkg::QRP_IDLE) begin
         state <= reset_recovering ? qrp_pkg::QRP_TAIL : qrp_pkg::QRP_OPCODE;
      end else if (sclk_rise) begin
         shift      <= next_shift;
         edge_count <= phase_last ? 5'h00 : edge_count + 5'h01;
         unique case (state)
            qrp_pkg::QRP_OPCODE: begin
               if (phase_last) begin
                  opcode      <= next_shift_byte;
                  opcode_done <= 1'b1;
                  wrap_read   <= (next_shift_byte == qrp_pkg::OP_WRAP_READ);
                  if (quad_mode && (next_shift_byte == qrp_pkg::OP_FAST_READ
                                    || next_shift_byte == qrp_pkg::OP_QUAD_IO_READ
                                    || next_shift_byte == qrp_pkg::OP_WRAP_READ)) begin
                     state       <= qrp_pkg::QRP_ADDR;
                     phase_edges <= qrp_pkg::QUAD_ADDR_EDGES;
                  end else if (quad_mode && next_shift_byte == qrp_pkg::OP_SET_READ_PARAM) begin
                     state       <= qrp_pkg::QRP_PARAM;
                     phase_edges <= qrp_pkg::PARAM_BYTE_EDGES;
                  end else if (!quad_mode && next_shift_byte == qrp_pkg::OP_SET_BURST_WRAP) begin
                     state       <= qrp_pkg::QRP_PARAM;
                     phase_edges <= qrp_pkg::WRAP_CFG_EDGES;
                  end else begin
                     state <= qrp_pkg::QRP_TAIL;
                  end
               end
            end
            qrp_pkg::QRP_PARAM: begin
               if (phase_last) begin
                  param_done <= 1'b1;
                  state      <= qrp_pkg::QRP_TAIL;
               end
            end
            qrp_pkg::QRP_ADDR: begin
               if (phase_last) begin
                  state       <= qrp_pkg::QRP_DUMMY;
                  phase_edges <= {1'b0, dummy_decode(dummy_sel)};
               end
            end
            qrp_pkg::QRP_DUMMY: begin
               if (phase_last) begin
                  state       <= qrp_pkg::QRP_DATA;
                  phase_edges <= qrp_pkg::BYTE_EDGES;
               end
            end
            qrp_pkg::QRP_DATA: begin
               state <= qrp_pkg::QRP_DATA;
            end
            qrp_pkg::QRP_TAIL: begin
               state <= qrp_pkg::QRP_TAIL;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Byte address requests: one after the dummy phase,
   // then one per byte, wrapping for the wrapped read.
   always_ff @(posedge core_clk) begin
      if (!resetn || take_reset) begin
         byte_addr <= 24'h000000;
         read_req  <= '0;
      end else begin
         read_req.strobe <= 1'b0;
         if (sclk_rise && cs_low) begin
            if (state == qrp_pkg::QRP_ADDR && phase_last) begin
               byte_addr <= next_shift;
            end else if (state == qrp_pkg::QRP_DUMMY && phase_last) begin
               read_req.strobe  <= 1'b1;
               read_req.wrapped <= wrap_read;
               read_req.addr    <= byte_addr;
            end else if (state == qrp_pkg::QRP_DATA && phase_last) begin
               byte_addr        <= next_address(byte_addr, wrap_read,
                                                wrap_decode(wrap_sel));
               read_req.strobe  <= 1'b1;
               read_req.wrapped <= wrap_read;
               read_req.addr    <= next_address(byte_addr, wrap_read,
                                                wrap_decode(wrap_sel));
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered view of mode and read configuration.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         four_bit_command_mode      <= 1'b0;
         quad_read_cfg.dummy_clocks <= dummy_decode(qrp_pkg::DUMMY_SEL_RESET);
         quad_read_cfg.wrap_bytes   <= wrap_decode(qrp_pkg::WRAP_SEL_RESET);
         wrap_setting_bits          <= qrp_pkg::WRAP_SETTING_RESET;
         active_dummy_clocks        <= qrp_pkg::SPI_FAST_READ_DUMMY;
      end else begin
         four_bit_command_mode      <= quad_mode;
         quad_read_cfg.dummy_clocks <= dummy_decode(dummy_sel);
         quad_read_cfg.wrap_bytes   <= wrap_decode(wrap_sel);
         wrap_setting_bits          <= {wrap_sel, spi_wrap_off};
         if (quad_mode) begin
            active_dummy_clocks <= dummy_decode(dummy_sel);
         end else if (opcode == qrp_pkg::OP_QUAD_IO_READ) begin
            active_dummy_clocks <= qrp_pkg::SPI_QUAD_IO_DUMMY;
         end else begin
            active_dummy_clocks <= qrp_pkg::SPI_FAST_READ_DUMMY;
         end
      end
   end

endmodule // qrp_mode_ctrl

// [tb/qrp_mode_ctrl_properties.sv]
/*
 * Checker of the mode and soft reset decoder at its ports.
 * Assumes the recovery time handed on by the bind.
 */
module qrp_mode_ctrl_chk #(
   parameter int RESET_RECOVERY_NS = 30000
) (
   input wire logic                      core_clk,
   input wire logic                      resetn,
   input wire logic                      quad_enable_bit,
   input wire logic                      four_bit_command_mode,
   input wire qrp_pkg::qrp_read_cfg_type quad_read_cfg,
   input wire logic [3:0]                active_dummy_clocks,
   input wire logic [2:0]                wrap_setting_bits,
   input wire qrp_pkg::qrp_read_req_type read_req,
   input wire logic                      volatile_clear,
   input wire logic                      reset_recovering
);
   localparam int REC_CYC = RESET_RECOVERY_NS / qrp_pkg::CLK_PERIOD_NS;
   logic [15:0] rec_cnt;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   ////////////////////////////////////////////////////////////////////////////
   // Cycles spent in reset recovery.
   always_ff @(posedge core_clk) begin
      if (!resetn || !reset_recovering) begin
         rec_cnt <= 16'h0000;
      end else begin
         rec_cnt <= rec_cnt + 16'h0001;
      end
   end

   // Reset defaults and a settled four bit mode.
   sequence s_defaults;
      !four_bit_command_mode && quad_read_cfg == {4'h2, 7'h08} && wrap_setting_bits == 3'h1
         && active_dummy_clocks == 4'h8;
   endsequence
   sequence s_qpi_settled;
      (four_bit_command_mode && $stable(quad_read_cfg)) [*4];
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   // Decoder outputs against their causes.
   AST_RESET_DEFAULTS: assert property ($rose(resetn) |-> s_defaults)
      else $error("bad values after reset release");
   AST_SOFT_RESET: assert property (volatile_clear |-> ##2 s_defaults)
      else $error("soft reset left settings");
   AST_CFG_CODES: assert property (
      quad_read_cfg.dummy_clocks inside {4'h2, 4'h4, 4'h6, 4'h8}
      && quad_read_cfg.wrap_bytes inside {7'h08, 7'h10, 7'h20, 7'h40})
      else $error("illegal read config code");
   AST_QPI_DUMMY: assert property (
      s_qpi_settled |-> active_dummy_clocks == quad_read_cfg.dummy_clocks)
      else $error("dummy count differs from params");
   AST_SPI_CFG_HELD: assert property (
      !four_bit_command_mode && !$past(four_bit_command_mode) && !volatile_clear
      && !$past(volatile_clear) |-> $stable(quad_read_cfg.dummy_clocks))
      else $error("dummy count changed in single line mode");
   AST_MODE_KEEPS_WRAP: assert property (
      $changed(four_bit_command_mode) && !$past(volatile_clear) && !$past(volatile_clear, 2)
      |-> $stable(wrap_setting_bits) && $stable(quad_read_cfg.wrap_bytes))
      else $error("mode change altered wrap length");
   AST_ENTER_NEEDS_QE: assert property (
      $rose(four_bit_command_mode) |-> $past(quad_enable_bit) && !$past(reset_recovering))
      else $error("four bit mode without quad enable");
   AST_RECOVERY_START: assert property (volatile_clear |-> ##2 reset_recovering [*8])
      else $error("no recovery after reset");
   AST_RECOVERY_HOLDS: assert property (
      reset_recovering [*3] |-> $stable(four_bit_command_mode) && $stable(quad_read_cfg))
      else $error("settings changed in recovery");
   AST_RECOVERY_BOUND: assert property (rec_cnt <= 16'(REC_CYC + 2))
      else $error("recovery too long");
   AST_STROBE_PULSE: assert property (
      read_req.strobe |-> four_bit_command_mode ##1 !read_req.strobe)
      else $error("bad read strobe");
endmodule // qrp_mode_ctrl_chk

bind qrp_mode_ctrl qrp_mode_ctrl_chk #(.RESET_RECOVERY_NS(RESET_RECOVERY_NS)) u_chk (
   .core_clk(core_clk), .resetn(resetn),
   .quad_enable_bit(quad_enable_bit), .four_bit_command_mode(four_bit_command_mode),
   .quad_read_cfg(quad_read_cfg), .active_dummy_clocks(active_dummy_clocks),
   .wrap_setting_bits(wrap_setting_bits), .read_req(read_req),
   .volatile_clear(volatile_clear), .reset_recovering(reset_recovering));

// [tb/qrp_host_model.sv]
/*
 * Host flash controller model driving the link.
 * Assumes the bench core clock; the 160 ns serial clock idles low.
 */
module qrp_host_model (
   input  wire logic       core_clk,
   output logic            sclk,
   output logic            cs_n,
   output logic [3:0]      io_in
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle link: clock still, chip select high.
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      io_in = 4'hA;
   end

   // Waits whole core cycles, then steps just past the edge.
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   // One serial clock pulse with a value set up on the data lines.
   task automatic edge_out(input logic [3:0] v);
      io_in = v;
      tick(8);
      sclk = 1'b1;
      tick(8);
      sclk = 1'b0;
   endtask

   // One whole frame: opcode, trailing nibbles, then dummy and data edges.
   task automatic frame(input logic spi, input logic [7:0] op, input logic [31:0] tail = 32'h0,
                        input int ntail = 0, input int nextra = 0);
      logic [31:0] t;
      t = tail;
      tick(1);
      cs_n = 1'b0;
      if (spi) begin
         for (int i = 7; i >= 0; i--) edge_out({~io_in[3:1], op[i]});
      end else begin
         edge_out(op[7:4]);
         edge_out(op[3:0]);
      end
      for (int i = 0; i < ntail; i++) begin
         edge_out(t[31:28]);
         t = t << 4;
      end
      for (int i = 0; i < nextra; i++) edge_out(~io_in);
      tick(4);
      cs_n = 1'b1;
      io_in = ~io_in;
      tick(10);
   endtask
endmodule // qrp_host_model

// [tb/tb_qrp_mode_ctrl.sv]
/*
 * Self-checking bench of the mode and soft reset decoder.
 * Assumes the host model and a short recovery time.
 */
module tb_qrp_mode_ctrl;
   timeunit 1ns;
   timeprecision 100ps;

   logic                      core_clk, resetn, sclk, cs_n, quad_enable_bit;
   logic                      four_bit_command_mode, volatile_clear, reset_recovering;
   logic [3:0]                io_in, active_dummy_clocks;
   logic [2:0]                wrap_setting_bits, w;
   qrp_pkg::qrp_read_cfg_type quad_read_cfg;
   qrp_pkg::qrp_read_req_type read_req;
   int                        error_cnt = 0, checks_done = 0, clr_cnt = 0;
   integer                    seed = 32'h2111CEA3;
   logic [24:0]               addr_q[$];
   logic [23:0]               a;
   logic [7:0]                p;

   // Core clock at 100 MHz.
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   qrp_mode_ctrl #(.RESET_RECOVERY_NS(3000)) dut (
      .core_clk(core_clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
      .quad_enable_bit(quad_enable_bit), .four_bit_command_mode(four_bit_command_mode),
      .quad_read_cfg(quad_read_cfg), .active_dummy_clocks(active_dummy_clocks),
      .wrap_setting_bits(wrap_setting_bits), .read_req(read_req),
      .volatile_clear(volatile_clear), .reset_recovering(reset_recovering));
   qrp_host_model host (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .io_in(io_in));

   ////////////////////////////////////////////////////////////////////////////
   // Expected dummy count, wrap length and next wrapped address.
   function automatic logic [3:0] exp_dummy(input logic [7:0] pb);
      return 4'h2 + {1'b0, pb[5:4], 1'b0};
   endfunction
   function automatic logic [6:0] exp_wrap(input logic [7:0] pb);
      return 7'h08 << pb[1:0];
   endfunction
   function automatic logic [23:0] wrap_next(input logic [23:0] ad, input logic [6:0] len);
      return (ad & ~24'(len - 7'h01)) | ((ad + 24'h000001) & 24'(len - 7'h01));
   endfunction

   // Compares one value and counts it.
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Records read strobes and clear pulses.
   always @(posedge core_clk) begin
      if (read_req.strobe === 1'b1) addr_q.push_back({read_req.wrapped, read_req.addr});
      if (volatile_clear === 1'b1) clr_cnt++;
   end

   // Cuts a hang short.
   initial begin
      repeat (40000) @(posedge core_clk);
      error_cnt++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      resetn = 1'b0;
      quad_enable_bit = 1'b0;
      host.tick(5);
      resetn = 1'b1;
      host.tick(3);
      check("mode", 32'h0, four_bit_command_mode);
      check("cfg", {4'h2, 7'h08}, quad_read_cfg);
      check("wrap_set", 32'h1, wrap_setting_bits);
      $display("test power_up done");
      host.frame(1'b1, 8'hC0, 32'h35000000, 2, 0);
      check("cfg", {4'h2, 7'h08}, quad_read_cfg);
      host.frame(1'b1, 8'h0B);
      check("dummy", 32'h8, active_dummy_clocks);
      host.frame(1'b1, 8'hEB);
      check("dummy", 32'h4, active_dummy_clocks);
      host.frame(1'b1, 8'h38);
      check("mode", 32'h0, four_bit_command_mode);
      p = 8'($random(seed));
      w = {p[5:4], p[4]};
      host.frame(1'b1, 8'h77, {24'h0, p}, 8, 0);
      check("wrap_set", w, wrap_setting_bits);
      quad_enable_bit = 1'b1;
      host.frame(1'b1, 8'h38);
      check("mode", 32'h1, four_bit_command_mode);
      check("wrap_set", w, wrap_setting_bits);
      $display("test spi_mode done");
      for (int i = 0; i < 4; i++) begin
         p = 8'($random(seed));
         p[5:4] = i[1:0];
         p[1:0] = ~i[1:0];
         host.frame(1'b0, 8'hC0, {p, 24'h0}, 2, 0);
         check("cfg", {exp_dummy(p), exp_wrap(p)}, quad_read_cfg);
         check("dummy", exp_dummy(p), active_dummy_clocks);
      end
      $display("test read_param done");
      for (int k = 0; k < 2; k++) begin
         p = (k == 0) ? 8'h00 : 8'($random(seed));
         a = (k == 0) ? 24'h00003E : 24'($random(seed));
         host.frame(1'b0, 8'hC0, {p, 24'h0}, 2, 0);
         addr_q.delete();
         host.frame(1'b0, 8'h0C, {a, 8'h0}, 6, int'(exp_dummy(p)) + 10);
         check("strobes", 32'h1, {31'h0, addr_q.size() >= 5});
         for (int j = 0; j < 5 && j < addr_q.size(); j++) begin
            check("addr", {1'b1, a}, addr_q[j]);
            a = wrap_next(a, exp_wrap(p));
         end
      end
      $display("test wrap_read done");
      host.frame(1'b0, 8'hFF);
      check("mode", 32'h0, four_bit_command_mode);
      check("wrap_set", {p[1:0], w[0]}, wrap_setting_bits);
      host.frame(1'b1, 8'h38);
      host.frame(1'b0, 8'h66);
      host.frame(1'b0, 8'h0B);
      host.frame(1'b0, 8'h99);
      check("clears", 32'h0, clr_cnt);
      check("mode", 32'h1, four_bit_command_mode);
      host.frame(1'b0, 8'h66);
      host.frame(1'b0, 8'h99);
      check("clears", 32'h1, clr_cnt);
      check("recovering", 32'h1, reset_recovering);
      host.frame(1'b1, 8'h38);
      check("mode", 32'h0, four_bit_command_mode);
      check("cfg", {4'h2, 7'h08}, quad_read_cfg);
      check("wrap_set", 32'h1, wrap_setting_bits);
      host.tick(200);
      check("recovering", 32'h0, reset_recovering);
      host.frame(1'b1, 8'h38);
      check("mode", 32'h1, four_bit_command_mode);
      $display("test soft_reset done");
      end_of_test();
   end
endmodule // tb_qrp_mode_ctrl
